// ### core/sra_pkg.sv
package sra_pkg;

  // ----------------------------------------
  // boundary table layout
  // ----------------------------------------
  localparam int BND_COUNT = 5;
  localparam logic [2:0] BND_CF_S = 3'h0;    // code flash: secure below this address
  localparam logic [2:0] BND_CF_NSC = 3'h1;  // code flash: callable below this address
  localparam logic [2:0] BND_DF_S = 3'h2;    // data flash: secure below this address
  localparam logic [2:0] BND_RAM_S = 3'h3;   // sram: secure below this address
  localparam logic [2:0] BND_RAM_NSC = 3'h4; // sram: callable below this address
  localparam logic [2:0] BND_LAST = 3'h4;
  localparam logic [31:0] BND_RST = 32'hffff_ffff; // all secure until loaded

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SRA_NS = 2'h0,
    SRA_S = 2'h1,
    SRA_NSC = 2'h2
  } sra_region_t;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_LOCKED = 3'b010,
    ST_RUNTIME = 3'b100
  } sra_state_t;

endpackage

// ### core/sra_attrib.sv
`timescale 1ns/1ps
module sra_attrib
  import sra_pkg::*;
#(
  parameter bit RUNTIME_CFG = 1'b0,
  parameter logic [31:0] CF_BASE = 32'h0000_0000,
  parameter logic [31:0] CF_END = 32'h0010_0000,
  parameter logic [31:0] DF_BASE = 32'h0800_0000,
  parameter logic [31:0] DF_END = 32'h0800_2000,
  parameter logic [31:0] RAM_BASE = 32'h2000_0000,
  parameter logic [31:0] RAM_END = 32'h2004_0000,
  parameter logic [31:0] EXT_BASE = 32'h6000_0000,
  parameter logic [31:0] GATEWAY_OPCODE = 32'h1234_5678
)(
  input wire logic clock,                 // system clock
  input wire logic rst,                   // async reset, active high
  input wire logic clk_en,                // freezes all state when low
  input wire logic i_valid,               // fetch bus access present
  input wire logic [31:0] i_addr,         // fetch address
  input wire logic i_secure,              // processor in secure state
  input wire logic [31:0] i_instr,        // fetched instruction word
  input wire logic d_valid,               // data bus access present
  input wire logic [31:0] d_addr,         // data address
  input wire logic d_secure,              // processor in secure state
  input wire logic nv_rd_valid,           // boundary word from storage
  input wire logic [31:0] nv_rd_data,     // word for nv_rd_idx
  input wire logic sw_wr,                 // application boundary write
  input wire logic [2:0] sw_idx,          // boundary index
  input wire logic [31:0] sw_data,        // boundary value
  input wire logic prog_wr,               // programming host write
  input wire logic [2:0] prog_idx,        // boundary index
  input wire logic [31:0] prog_data,      // boundary value
  input wire logic secure_debug_lifecycle_state, // lifecycle allows programming
  output logic [2:0] nv_rd_idx_q,         // boundary word requested
  output logic nv_wr_en_q,                // storage write strobe
  output logic [2:0] nv_wr_idx_q,         // storage write index
  output logic [31:0] nv_wr_data_q,       // storage write data
  output logic prog_reject_q,             // programming write refused
  output logic sw_reject_q,               // application write ignored
  output logic ready_q,                   // boundaries valid
  output logic i_done_q,                  // fetch verdict valid
  output sra_region_t i_region_q,         // fetch region
  output logic i_fault_q,                 // fetch security exception
  output logic d_done_q,                  // data verdict valid
  output sra_region_t d_region_q,         // data region
  output logic d_fault_q                  // data security exception
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    sra_state_t st;
    logic rdy;
    logic [BND_COUNT-1:0][31:0] bnd;
    logic [2:0] rd_idx;
    logic nv_wr;
    logic [2:0] nv_idx;
    logic [31:0] nv_data;
    logic prog_rej;
    logic sw_rej;
    logic i_done;
    sra_region_t i_reg;
    logic i_flt;
    logic d_done;
    sra_region_t d_reg;
    logic d_flt;
  } sra_regs_t;

  sra_regs_t r_q, r_d;
  sra_region_t i_cls, d_cls;

  // ----------------------------------------
  // classification
  // ----------------------------------------
  function automatic sra_region_t classify(input logic [31:0] a, input logic [BND_COUNT-1:0][31:0] b);
    sra_region_t c;
    c = SRA_NS; // peripherals are filtered elsewhere
    if (a >= EXT_BASE)
      c = SRA_NS;
    else if (a >= CF_BASE && a < CF_END)
    begin
      if (a < b[BND_CF_S])
        c = SRA_S;
      else if (a < b[BND_CF_NSC])
        c = SRA_NSC;
    end
    else if (a >= DF_BASE && a < DF_END)
    begin
      if (a < b[BND_DF_S])
        c = SRA_S;
    end
    else if (a >= RAM_BASE && a < RAM_END)
    begin
      if (a < b[BND_RAM_S])
        c = SRA_S;
      else if (a < b[BND_RAM_NSC])
        c = SRA_NSC;
    end
    return c;
  endfunction

  assign i_cls = classify(i_addr, r_q.bnd);
  assign d_cls = classify(d_addr, r_q.bnd);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic rdy;
    rdy = r_q.rdy;
    r_d = r_q;
    r_d.nv_wr = 1'b0;
    r_d.prog_rej = 1'b0;
    r_d.sw_rej = 1'b0;
    case (r_q.st)
      ST_LOAD:
      begin
        if (nv_rd_valid)
        begin
          r_d.bnd[r_q.rd_idx] = nv_rd_data;
          if (r_q.rd_idx == BND_LAST)
            r_d.st = RUNTIME_CFG ? ST_RUNTIME : ST_LOCKED;
          else
            r_d.rd_idx = r_q.rd_idx + 3'h1;
        end
      end
      ST_LOCKED:
        r_d.sw_rej = sw_wr;
      ST_RUNTIME:
      begin
        if (sw_wr && sw_idx <= BND_LAST)
          r_d.bnd[sw_idx] = sw_data;
        else
          r_d.sw_rej = sw_wr;
      end
      default:
        r_d.st = ST_LOAD;
    endcase
    // kept as its own flop so ready_q needs no decode of the state
    r_d.rdy = (r_d.st != ST_LOAD);
    if (r_q.st == ST_LOAD)
      r_d.sw_rej = sw_wr; // too early: boundaries not yet settled
    // programming goes to storage only, takes effect at next reset
    if (prog_wr)
    begin
      if (secure_debug_lifecycle_state && prog_idx <= BND_LAST)
      begin
        r_d.nv_wr = 1'b1;
        r_d.nv_idx = prog_idx;
        r_d.nv_data = prog_data;
      end
      else
        r_d.prog_rej = 1'b1;
    end
    r_d.i_done = i_valid;
    r_d.i_reg = i_cls;
    r_d.i_flt = 1'b0;
    if (i_valid && !i_secure)
    begin
      if (!rdy || i_cls == SRA_S)
        r_d.i_flt = 1'b1;
      else if (i_cls == SRA_NSC && i_instr != GATEWAY_OPCODE)
        r_d.i_flt = 1'b1;
    end
    r_d.d_done = d_valid;
    r_d.d_reg = d_cls;
    // callable holds veneers to execute, not data for non-secure code
    r_d.d_flt = d_valid && !d_secure && (!rdy || d_cls != SRA_NS);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      r_q <= '0;
      r_q.st <= ST_LOAD;
      r_q.bnd <= {BND_COUNT{BND_RST}};
      r_q.i_reg <= SRA_NS;
      r_q.d_reg <= SRA_NS;
    end
    else if (clk_en)
      r_q <= r_d;
  end

  assign nv_rd_idx_q = r_q.rd_idx;
  assign nv_wr_en_q = r_q.nv_wr;
  assign nv_wr_idx_q = r_q.nv_idx;
  assign nv_wr_data_q = r_q.nv_data;
  assign prog_reject_q = r_q.prog_rej;
  assign sw_reject_q = r_q.sw_rej;
  assign ready_q = r_q.rdy;
  assign i_done_q = r_q.i_done;
  assign i_region_q = r_q.i_reg;
  assign i_fault_q = r_q.i_flt;
  assign d_done_q = r_q.d_done;
  assign d_region_q = r_q.d_reg;
  assign d_fault_q = r_q.d_flt;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  secure_fetch_ok_a: assert property (@(posedge clock) disable iff (rst)
    clk_en && i_valid && i_secure |=> !i_fault_q)
    else $error("secure fetch faulted");
  secure_data_ok_a: assert property (@(posedge clock) disable iff (rst)
    clk_en && d_valid && d_secure |=> !d_fault_q)
    else $error("secure data access faulted");
  ext_is_ns_a: assert property (@(posedge clock) disable iff (rst)
    clk_en && d_valid && d_addr >= EXT_BASE |=> d_region_q == SRA_NS && d_done_q)
    else $error("external access not non-secure");
  ns_data_gate_a: assert property (@(posedge clock) disable iff (rst)
    clk_en && d_valid && !d_secure && ready_q |=> d_fault_q == (d_region_q != SRA_NS))
    else $error("non-secure data verdict wrong");
  gateway_entry_a: assert property (@(posedge clock) disable iff (rst)
    clk_en && i_valid && !i_secure && ready_q && i_cls == SRA_NSC
    |=> i_fault_q == ($past(i_instr) != GATEWAY_OPCODE))
    else $error("gateway entry verdict wrong");
  ns_fetch_s_a: assert property (@(posedge clock) disable iff (rst)
    clk_en && i_valid && !i_secure && i_cls == SRA_S |=> i_fault_q && i_region_q == SRA_S)
    else $error("non-secure fetch into secure not faulted");
  lock_hold_a: assert property (@(posedge clock) disable iff (rst)
    r_q.st == ST_LOCKED |=> $stable(r_q.bnd) && r_q.st == ST_LOCKED)
    else $error("locked boundaries changed");
  prog_gate_a: assert property (@(posedge clock) disable iff (rst)
    clk_en && prog_wr && !secure_debug_lifecycle_state |=> !nv_wr_en_q && prog_reject_q)
    else $error("programming accepted outside debug state");
  both_buses_a: assert property (@(posedge clock) disable iff (rst)
    clk_en && i_valid && d_valid |=> i_done_q && d_done_q)
    else $error("same-cycle accesses not both checked");
  runtime_write_a: assert property (@(posedge clock) disable iff (rst)
    clk_en && r_q.st == ST_RUNTIME && sw_wr && sw_idx <= BND_LAST |=> r_q.bnd[$past(sw_idx)] == $past(sw_data))
    else $error("runtime boundary write lost");

  gateway_call_c: cover property (@(posedge clock) disable iff (rst)
    clk_en && i_valid && !i_secure && i_cls == SRA_NSC && i_instr == GATEWAY_OPCODE);
  load_done_c: cover property (@(posedge clock) disable iff (rst) !ready_q ##1 ready_q);
  data_fault_c: cover property (@(posedge clock) disable iff (rst) d_fault_q && ready_q);

endmodule

// ### test/sra_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// processor core: fetch and data bus driver
// ----------------------------------------
module sra_core_model(
  input wire logic clock, // system clock
  input wire logic rst, // async reset
  input wire logic issue, // bench asks for an access
  input wire logic [31:0] addr, // target address
  input wire logic sec, // secure state
  input wire logic [31:0] instr, // fetched word
  output logic i_valid, // fetch present
  output logic [31:0] i_addr, // fetch address
  output logic i_secure, // fetch state
  output logic [31:0] i_instr, // fetch word
  output logic d_valid, // data present
  output logic [31:0] d_addr, // data address
  output logic d_secure // data state
);
  // idle buses churn so stale values never look valid
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      {i_valid, i_addr, i_secure, i_instr} <= '0;
      {d_valid, d_addr, d_secure} <= '0;
    end
    else if (issue)
    begin
      {i_valid, i_addr, i_secure, i_instr} <= {1'b1, addr, sec, instr};
      {d_valid, d_addr, d_secure} <= {1'b1, addr, sec};
    end
    else
    begin
      {i_valid, i_addr, i_secure, i_instr} <= {1'b0, ~i_addr, ~i_secure, ~i_instr};
      {d_valid, d_addr, d_secure} <= {1'b0, ~d_addr, ~d_secure};
    end
  end
endmodule

// ### test/security_region_attribution_test.sv
`timescale 1ns/1ps
module security_region_attribution_test;
  import sra_pkg::*;
  typedef struct packed {logic [31:0] a; logic s; logic g; logic [1:0] r; logic fi; logic fd;} sra_row_t;
  localparam logic [31:0] GW = 32'h1234_5678;
  logic clock = 1'b0, rst = 1'b1, clk_en = 1'b1, issue = 1'b0, req_sec = 1'b0, nv_rd_valid = 1'b0;
  logic sw_wr = 1'b0, prog_wr = 1'b0, lc = 1'b0;
  logic [2:0] sw_idx = 3'h0, prog_idx = 3'h0;
  logic [31:0] req_addr = '0, req_instr = '0, sw_data = '0, prog_data = '0, nv_rd_data;
  logic i_valid, i_secure, d_valid, d_secure, nv_wr_en_q, prog_reject_q, sw_reject_q, ready_q;
  logic i_done_q, i_fault_q, d_done_q, d_fault_q, rt_sw_reject, rt_i_fault;
  logic [31:0] i_addr, i_instr, d_addr, nv_wr_data_q;
  logic [2:0] nv_rd_idx_q, nv_wr_idx_q;
  sra_region_t i_region_q, d_region_q, rt_i_region;
  int n_mismatch = 0, comparisons = 0;
  logic [31:0] bnd [5] = '{32'h0004_0000, 32'h0004_8000, 32'h0800_1000, 32'h2002_0000, 32'h2002_8000};
  sra_row_t rows [11] = '{
    '{32'h0000_0100, 1'b0, 1'b0, 2'h1, 1'b1, 1'b1}, '{32'h0000_0100, 1'b1, 1'b0, 2'h1, 1'b0, 1'b0},
    '{32'h0004_0000, 1'b0, 1'b1, 2'h2, 1'b0, 1'b1}, '{32'h0004_0004, 1'b0, 1'b0, 2'h2, 1'b1, 1'b1},
    '{32'h0004_8000, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0}, '{32'h0800_0000, 1'b0, 1'b0, 2'h1, 1'b1, 1'b1},
    '{32'h0800_1000, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0}, '{32'h2002_4000, 1'b0, 1'b1, 2'h2, 1'b0, 1'b1},
    '{32'h6000_0000, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0}, '{32'hffff_ffff, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0},
    '{32'h2001_fffc, 1'b1, 1'b0, 2'h1, 1'b0, 1'b0}};
  assign nv_rd_data = bnd[nv_rd_idx_q];
  always #25 clock = ~clock;
  sra_core_model u_core(.clock(clock), .rst(rst), .issue(issue), .addr(req_addr), .sec(req_sec),
    .instr(req_instr), .i_valid(i_valid), .i_addr(i_addr), .i_secure(i_secure), .i_instr(i_instr),
    .d_valid(d_valid), .d_addr(d_addr), .d_secure(d_secure));
  sra_attrib #(.GATEWAY_OPCODE(GW)) u_dut(.clock(clock), .rst(rst), .clk_en(clk_en), .i_valid(i_valid),
    .i_addr(i_addr),
    .i_secure(i_secure), .i_instr(i_instr), .d_valid(d_valid), .d_addr(d_addr), .d_secure(d_secure),
    .nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data), .sw_wr(sw_wr), .sw_idx(sw_idx), .sw_data(sw_data),
    .prog_wr(prog_wr), .prog_idx(prog_idx), .prog_data(prog_data), .secure_debug_lifecycle_state(lc),
    .nv_rd_idx_q(nv_rd_idx_q), .nv_wr_en_q(nv_wr_en_q), .nv_wr_idx_q(nv_wr_idx_q), .nv_wr_data_q(nv_wr_data_q),
    .prog_reject_q(prog_reject_q), .sw_reject_q(sw_reject_q), .ready_q(ready_q), .i_done_q(i_done_q),
    .i_region_q(i_region_q), .i_fault_q(i_fault_q), .d_done_q(d_done_q), .d_region_q(d_region_q),
    .d_fault_q(d_fault_q));
  sra_attrib #(.RUNTIME_CFG(1'b1), .GATEWAY_OPCODE(GW)) u_rt(.clock(clock), .rst(rst), .clk_en(clk_en),
    .i_valid(i_valid),
    .i_addr(i_addr), .i_secure(i_secure), .i_instr(i_instr), .d_valid(d_valid), .d_addr(d_addr),
    .d_secure(d_secure), .nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data), .sw_wr(sw_wr), .sw_idx(sw_idx),
    .sw_data(sw_data), .prog_wr(prog_wr), .prog_idx(prog_idx), .prog_data(prog_data),
    .secure_debug_lifecycle_state(lc), .nv_rd_idx_q(), .nv_wr_en_q(), .nv_wr_idx_q(), .nv_wr_data_q(),
    .prog_reject_q(), .sw_reject_q(rt_sw_reject), .ready_q(), .i_done_q(), .i_region_q(rt_i_region),
    .i_fault_q(rt_i_fault), .d_done_q(), .d_region_q(), .d_fault_q());
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task acc(input sra_row_t r);
    @(posedge clock);
    {issue, req_addr, req_sec, req_instr} <= {1'b1, r.a, r.s, r.g ? GW : ~GW};
    @(posedge clock);
    issue <= 1'b0;
    // core model registers the request, so the verdict lands one edge later
    @(posedge clock);
    @(negedge clock);
    chk("i_done", i_done_q, 1);
    chk("d_done", d_done_q, 1);
    chk("i_region", i_region_q, r.r);
    chk("d_region", d_region_q, r.r);
    chk("i_fault", i_fault_q, r.fi);
    chk("d_fault", d_fault_q, r.fd);
  endtask
  task cmd(input logic sw, input logic pg, input logic [2:0] idx, input logic [31:0] dat);
    @(posedge clock);
    {sw_wr, prog_wr, sw_idx, prog_idx, sw_data, prog_data} <= {sw, pg, idx, idx, dat, dat};
    @(posedge clock);
    {sw_wr, prog_wr} <= 2'b00;
    @(negedge clock);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #(50 * 600);
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    acc('{32'h0004_8000, 1'b0, 1'b0, 2'h1, 1'b1, 1'b1});
    chk("ready", ready_q, 0);
    @(posedge clock);
    nv_rd_valid <= 1'b1;
    repeat (5) @(posedge clock);
    nv_rd_valid <= 1'b0;
    @(negedge clock);
    chk("ready", ready_q, 1);
    chk("nv_rd_idx", nv_rd_idx_q, 4);
    $display("test load done");
    foreach (rows[k])
      acc(rows[k]);
    $display("test table done");
    cmd(1'b1, 1'b0, 3'h0, 32'h0);
    chk("sw_reject", sw_reject_q, 1);
    chk("rt_sw_reject", rt_sw_reject, 0);
    acc(rows[0]);
    chk("rt_i_region", rt_i_region, 2'h2);
    chk("rt_i_fault", rt_i_fault, 1);
    $display("test runtime done");
    @(posedge clock);
    clk_en <= 1'b0;
    cmd(1'b1, 1'b1, 3'h1, 32'h0000_00aa);
    chk("sw_reject", sw_reject_q, 0);
    chk("prog_reject", prog_reject_q, 0);
    @(posedge clock);
    clk_en <= 1'b1;
    $display("test freeze done");
    cmd(1'b0, 1'b1, 3'h1, 32'h0000_0055);
    chk("prog_reject", prog_reject_q, 1);
    chk("nv_wr_en", nv_wr_en_q, 0);
    @(posedge clock);
    lc <= 1'b1;
    cmd(1'b0, 1'b1, 3'h1, 32'h0000_0055);
    chk("nv_wr_en", nv_wr_en_q, 1);
    chk("nv_wr_idx", nv_wr_idx_q, 3'h1);
    chk("nv_wr_data", nv_wr_data_q, 32'h0000_0055);
    cmd(1'b1, 1'b1, 3'h5, 32'h0);
    chk("prog_reject", prog_reject_q, 1);
    chk("nv_wr_en", nv_wr_en_q, 0);
    chk("sw_reject", sw_reject_q, 1);
    chk("rt_sw_reject", rt_sw_reject, 1);
    acc(rows[3]);
    $display("test programming done");
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk("ready", ready_q, 0);
    chk("nv_rd_idx", nv_rd_idx_q, 0);
    chk("nv_wr_en", nv_wr_en_q, 0);
    chk("i_done", i_done_q, 0);
    acc('{32'h0004_8000, 1'b0, 1'b0, 2'h1, 1'b1, 1'b1});
    $display("test reset done");
    give_verdict();
  end
endmodule
